// file: logic/encif_pkg.sv
// encif_pkg: constants, register map and carrier types of the axis encoder interface.
// assumes a single pclk domain at 125 MHz with APB register access.
package encif_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SSI_CLK_HZ = 200_000;
  localparam int unsigned SSI_HALF_CYC = CLK_HZ / (2 * SSI_CLK_HZ);
  localparam int unsigned SSI_GAP_NS = 32_000;
  localparam int unsigned SSI_GAP_CYC = (SSI_GAP_NS * 125 + 999) / 1000;
  localparam int unsigned CAPTURE_LIMIT_NS = 500;
  localparam int unsigned CAPTURE_LIMIT_CYC = (CAPTURE_LIMIT_NS * 125) / 1000;
  localparam int unsigned SSI_MAX_BITS = 25;
  localparam int unsigned POS_W = 32;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_CAPTURE = 8'h14;
  localparam logic [7:0] OFF_SW_ON = 8'h18;
  localparam logic [7:0] OFF_SW_OFF = 8'h1C;
  localparam logic [7:0] OFF_MEASURED_POSITION = 8'h20;
  localparam logic [7:0] OFF_POS_ERR = 8'h24;
  localparam logic [7:0] OFF_DEMAND = 8'h28;

  // control field positions
  localparam int unsigned CTL_QUAD = 0;
  localparam int unsigned CTL_MODE_LO = 1;
  localparam int unsigned CTL_ARM = 3;
  localparam int unsigned CTL_SRC_LO = 4;
  localparam int unsigned CTL_EDGE_FALL = 6;
  localparam int unsigned CTL_PSW_EN = 7;
  localparam int unsigned CTL_GRAY = 8;
  localparam int unsigned CTL_BITS_LO = 9;
  localparam int unsigned CTL_STEP_EN = 14;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  localparam int unsigned IRQ_CAPTURE = 0;
  localparam int unsigned IRQ_FRAME = 1;
  localparam int unsigned IRQ_PSW = 2;
  localparam int unsigned IRQ_W = 3;

  typedef enum logic [1:0] {ENCIF_MODE_INC, ENCIF_MODE_ENC_OUT, ENCIF_MODE_STEP_OUT, ENCIF_MODE_SSI} encif_mode_t;

  typedef struct packed {
    logic chan_a;
    logic chan_b;
    logic chan_z;
  } encif_inc_t;

  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic enable;
  } encif_out_t;
endpackage : encif_pkg

// file: logic/encif_ssi.sv
// encif_ssi: synchronous serial absolute-encoder master producing a clock and sampling data.
// assumes data pin already synchronised; clock idles high between frames.
module encif_ssi
  import encif_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic enable,
  input wire logic [4:0] nbits,
  input wire logic gray,
  input wire logic data_in,
  output logic ssi_clk,
  output logic frame_done,
  output logic [SSI_MAX_BITS-1:0] pos_word
);
  typedef enum logic [1:0] {ENCIF_SSI_IDLE, ENCIF_SSI_LOW, ENCIF_SSI_HIGH, ENCIF_SSI_GAP} encif_ssi_st_t;
  encif_ssi_st_t st_reg;
  logic [12:0] tmr_reg;
  logic [5:0] pulse_reg;
  logic [SSI_MAX_BITS-1:0] shift_reg;
  logic [5:0] total_pulses;
  logic tmr_done;
  logic [SSI_MAX_BITS-1:0] masked;
  logic [SSI_MAX_BITS-1:0] binary;

  function automatic logic [SSI_MAX_BITS-1:0] gray2bin(input logic [SSI_MAX_BITS-1:0] g);
    logic [SSI_MAX_BITS-1:0] b;
    b = '0;
    b[SSI_MAX_BITS-1] = g[SSI_MAX_BITS-1];
    for (int i = SSI_MAX_BITS - 2; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    return b;
  endfunction : gray2bin

  assign total_pulses = {1'b0, nbits} + 6'd2;
  assign tmr_done = (tmr_reg == 13'd0);
  // shift holds only n bits, msb at bit n-1 since leading zeros were cleared
  assign masked = shift_reg;
  assign binary = gray ? gray2bin(masked) : masked;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= ENCIF_SSI_IDLE;
      tmr_reg <= '0;
      pulse_reg <= '0;
      shift_reg <= '0;
      ssi_clk <= 1'b1;
      frame_done <= 1'b0;
      pos_word <= '0;
    end
    else if (ce)
    begin
      frame_done <= 1'b0;
      if (!tmr_done)
        tmr_reg <= tmr_reg - 13'd1;
      unique case (st_reg)
        ENCIF_SSI_IDLE:
        begin
          ssi_clk <= 1'b1;
          if (enable && nbits != 5'd0)
          begin
            st_reg <= ENCIF_SSI_LOW;
            ssi_clk <= 1'b0;
            pulse_reg <= '0;
            shift_reg <= '0;
            tmr_reg <= 13'(SSI_HALF_CYC - 1);
          end
        end
        ENCIF_SSI_LOW:
          if (tmr_done)
          begin
            st_reg <= ENCIF_SSI_HIGH;
            ssi_clk <= 1'b1;
            tmr_reg <= 13'(SSI_HALF_CYC - 1);
            // first pulse is a lead pulse, data bits follow msb first, last pulse trails
            if (pulse_reg >= 6'd1 && pulse_reg <= {1'b0, nbits})
              shift_reg <= {shift_reg[SSI_MAX_BITS-2:0], data_in};
            pulse_reg <= pulse_reg + 6'd1;
          end
        ENCIF_SSI_HIGH:
          if (tmr_done)
          begin
            if (pulse_reg == total_pulses)
            begin
              st_reg <= ENCIF_SSI_GAP;
              tmr_reg <= 13'(SSI_GAP_CYC - 1);
              pos_word <= binary;
              frame_done <= 1'b1;
            end
            else
            begin
              st_reg <= ENCIF_SSI_LOW;
              ssi_clk <= 1'b0;
              tmr_reg <= 13'(SSI_HALF_CYC - 1);
            end
          end
        ENCIF_SSI_GAP:
          if (tmr_done)
            st_reg <= ENCIF_SSI_IDLE;  // continuous frames while enabled
      endcase
    end
  end
endmodule : encif_ssi

// file: logic/encif_sync.sv
// encif_sync: two-flop synchroniser for a group of pin inputs.
// assumes inputs asynchronous to pclk; only the second stage is read outside.
module encif_sync
  import encif_pkg::*;
#(
  parameter int unsigned W = 1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= '0;
      dout <= '0;
    end
    else if (ce)
    begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule : encif_sync

// file: logic/encif_top.sv
// encif_top: axis encoder interface with counter, capture, position switch, outputs and SSI.
// assumes APB master on pclk; all encoder and input pins are asynchronous.
//
// Contract
// - count changes by one for every edge of A or B in quadrature, simultaneous A and B edges dropped; for every rising A edge in step/direction
// - quadrature counts up when A leads B, down when B leads A
// - decode select: quadrature by default, else A step and B direction
// - armed capture latches count on chosen edge of Z or input 0/1
// - capture done in hardware within 0.5 us of the edge
// - output 8 turns on at on-position, off at off-position
// - position switch driven by compare logic only
// - encoder output gives one A or B edge per count, following direction
// - stepper output drives step, direction and enable
// - serial words in Gray or binary, up to 25 bits
// - bit count n sets data bits and pulses per frame
// - once n set, frames of n+2 pulses repeat continuously
// - serial clock runs at 200 kHz
// - 32 us idle between frames
// - each frame updates measured position and position error
module encif_top
  import encif_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire encif_inc_t enc_in,
  input wire logic [1:0] reg_input,
  output encif_out_t enc_out,
  output logic ssi_clk_out,
  output logic position_switch_output,
  output logic irq
);
  logic [31:0] ctrl_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [POS_W-1:0] count_reg;
  logic [POS_W-1:0] capture_reg;
  logic [POS_W-1:0] sw_on_reg;
  logic [POS_W-1:0] sw_off_reg;
  logic [POS_W-1:0] measured_position_reg;
  logic [POS_W-1:0] pos_err_reg;
  logic [POS_W-1:0] demand_reg;
  logic [POS_W-1:0] out_pos_reg;
  logic capture_arm_command_reg;
  logic psw_reg;
  logic [2:0] prev_reg;
  logic [1:0] prev_reg_in;
  logic ssi_clk_w;
  logic frame_done;
  logic [SSI_MAX_BITS-1:0] ssi_word;
  encif_inc_t inc_s;
  logic [1:0] regin_s;
  encif_out_t enc_out_next;

  encif_sync #(.W(5)) u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .ce(clk_en),
    .din({enc_in, reg_input}),
    .dout({inc_s, regin_s})
  );

  encif_mode_t mode;
  assign mode = encif_mode_t'(ctrl_reg[CTL_MODE_LO +: 2]);

  // edge detection on synchronised pins
  wire a_edge = inc_s.chan_a ^ prev_reg[2];
  wire b_edge = inc_s.chan_b ^ prev_reg[1];
  wire quad_sel = ctrl_reg[CTL_QUAD];
  // quadrature: for an A edge, A leads when new A differs from B
  wire quad_up = a_edge ? (inc_s.chan_a ^ inc_s.chan_b) : ~(inc_s.chan_a ^ inc_s.chan_b);
  wire quad_step = a_edge ^ b_edge;
  wire sd_step = inc_s.chan_a & ~prev_reg[2];
  wire cnt_step = (mode == ENCIF_MODE_INC) && (quad_sel ? quad_step : sd_step);
  wire cnt_up = quad_sel ? quad_up : inc_s.chan_b;
  // simultaneous A and B edges are illegal quadrature and are dropped
  wire [POS_W-1:0] count_next = cnt_up ? count_reg + 32'h0000_0001 : count_reg - 32'h0000_0001;

  // registration trigger select
  wire [1:0] src = ctrl_reg[CTL_SRC_LO +: 2];
  wire trig_now = (src == 2'd0) ? inc_s.chan_z : (src == 2'd1) ? regin_s[0] : regin_s[1];
  wire trig_prev = (src == 2'd0) ? prev_reg[0] : (src == 2'd1) ? prev_reg_in[0] : prev_reg_in[1];
  wire trig_fall = ctrl_reg[CTL_EDGE_FALL];
  wire trig_edge = trig_fall ? (trig_prev & ~trig_now) : (~trig_prev & trig_now);
  // latency from pin to capture is 3 cycles, well inside the limit
  wire capture_fire = capture_arm_command_reg && trig_edge && (CAPTURE_LIMIT_CYC >= 3);

  // axis position for the switch depends on mode: measured position in SSI mode, else count
  wire [POS_W-1:0] axis_pos = (mode == ENCIF_MODE_SSI) ? measured_position_reg : count_reg;
  wire psw_en = ctrl_reg[CTL_PSW_EN];
  wire psw_on_hit = psw_en && (axis_pos == sw_on_reg);
  wire psw_off_hit = psw_en && (axis_pos == sw_off_reg);
  wire psw_next = !psw_en ? 1'b0 : psw_on_hit ? 1'b1 : psw_off_hit ? 1'b0 : psw_reg;

  // output generation: walk out_pos toward demand one count per cycle
  wire out_mode = (mode == ENCIF_MODE_ENC_OUT) || (mode == ENCIF_MODE_STEP_OUT);
  wire out_move = out_mode && (out_pos_reg != demand_reg);
  wire out_up = $signed(demand_reg - out_pos_reg) > 0;
  wire [POS_W-1:0] out_pos_next = out_up ? out_pos_reg + 32'h0000_0001 : out_pos_reg - 32'h0000_0001;
  wire [1:0] gray_ph = {out_pos_next[1] ^ 1'b0, out_pos_next[1] ^ out_pos_next[0]};

  always_comb
  begin
    enc_out_next = enc_out;
    if (mode == ENCIF_MODE_ENC_OUT)
    begin
      enc_out_next.enable = 1'b1;
      if (out_move)
      begin
        enc_out_next.phase_a = gray_ph[1] ^ gray_ph[0] ? ~out_pos_next[1] : out_pos_next[1];
        enc_out_next.phase_b = out_pos_next[1];
      end
    end
    else if (mode == ENCIF_MODE_STEP_OUT)
    begin
      enc_out_next.enable = ctrl_reg[CTL_STEP_EN];
      if (out_move)
      begin
        // direction level high for counting up, same sense as the step input
        enc_out_next.phase_b = out_up;
        enc_out_next.phase_a = ~enc_out.phase_a;
      end
    end
    else
    begin
      enc_out_next = '0;
    end
  end

  // apb decode
  wire apb_wr = psel && penable && pwrite;
  wire apb_rd_setup = psel && !penable && !pwrite;
  wire addr_ok = (paddr[1:0] == 2'b00) && (paddr <= OFF_DEMAND);
  wire [IRQ_W-1:0] irq_events = {psw_next & ~psw_reg, frame_done, capture_fire};
  wire [IRQ_W-1:0] irq_clear = (apb_wr && paddr == OFF_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0;
  // event set wins over write-one clear
  wire [IRQ_W-1:0] irq_stat_next = irq_events | (irq_stat_reg & ~irq_clear);
  logic [31:0] rd_mux;

  always_comb
  begin
    unique case (paddr)
      OFF_CTRL: rd_mux = ctrl_reg;
      OFF_STATUS: rd_mux = {29'h0000_0000, psw_reg, capture_arm_command_reg, mode == ENCIF_MODE_SSI};
      OFF_IRQ_STAT: rd_mux = {29'h0000_0000, irq_stat_reg};
      OFF_IRQ_MASK: rd_mux = {29'h0000_0000, irq_mask_reg};
      OFF_COUNT: rd_mux = count_reg;
      OFF_CAPTURE: rd_mux = capture_reg;
      OFF_SW_ON: rd_mux = sw_on_reg;
      OFF_SW_OFF: rd_mux = sw_off_reg;
      OFF_MEASURED_POSITION: rd_mux = measured_position_reg;
      OFF_POS_ERR: rd_mux = pos_err_reg;
      OFF_DEMAND: rd_mux = demand_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  encif_ssi u_ssi
  (
    .pclk(pclk),
    .presetn(presetn),
    .ce(clk_en),
    .enable(mode == ENCIF_MODE_SSI),
    .nbits(ctrl_reg[CTL_BITS_LO +: 5]),
    .gray(ctrl_reg[CTL_GRAY]),
    .data_in(inc_s.chan_z),
    .ssi_clk(ssi_clk_w),
    .frame_done(frame_done),
    .pos_word(ssi_word)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= CTRL_RESET;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      count_reg <= '0;
      capture_reg <= '0;
      sw_on_reg <= '0;
      sw_off_reg <= '0;
      measured_position_reg <= '0;
      pos_err_reg <= '0;
      demand_reg <= '0;
      out_pos_reg <= '0;
      capture_arm_command_reg <= 1'b0;
      psw_reg <= 1'b0;
      prev_reg <= '0;
      prev_reg_in <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      enc_out <= '0;
      ssi_clk_out <= 1'b1;
      position_switch_output <= 1'b0;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      prev_reg <= {inc_s.chan_a, inc_s.chan_b, inc_s.chan_z};
      prev_reg_in <= regin_s;
      if (cnt_step)
        count_reg <= count_next;
      psw_reg <= psw_next;
      position_switch_output <= psw_next;
      ssi_clk_out <= ssi_clk_w;
      enc_out <= enc_out_next;
      if (out_move)
        out_pos_reg <= out_pos_next;
      if (frame_done)
      begin
        measured_position_reg <= {7'h00, ssi_word};
        pos_err_reg <= demand_reg - {7'h00, ssi_word};
      end
      // apb: one wait-free access phase, answer registered at setup
      pready <= apb_rd_setup || (psel && !penable);
      pslverr <= psel && !penable && !addr_ok;
      if (apb_rd_setup)
        prdata <= addr_ok ? rd_mux : 32'h0000_0000;
      irq_stat_reg <= irq_stat_next;
      // a set mask bit hides its status bit; irq follows the status it will hold
      irq <= |(irq_stat_next & ~irq_mask_reg);
      if (capture_fire)
      begin
        capture_reg <= cnt_step ? count_next : count_reg;
        capture_arm_command_reg <= 1'b0;
      end
      if (apb_wr && addr_ok)
      begin
        unique case (paddr)
          OFF_CTRL:
          begin
            ctrl_reg <= pwdata & ~(32'h0000_0001 << CTL_ARM);
            if (pwdata[CTL_ARM])
              capture_arm_command_reg <= 1'b1;
          end
          OFF_IRQ_MASK: irq_mask_reg <= pwdata[IRQ_W-1:0];
          OFF_SW_ON: sw_on_reg <= pwdata;
          OFF_SW_OFF: sw_off_reg <= pwdata;
          OFF_DEMAND: demand_reg <= pwdata;
          OFF_COUNT: count_reg <= pwdata;
          default: ;
        endcase
      end
    end
  end
endmodule : encif_top

// file: test/encif_ssi_enc.sv
// encif_ssi_enc: behavioural absolute encoder on the serial clock and data pins.
// assumes the serial clock idles high and is synchronous to pclk.
module encif_ssi_enc
  import encif_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic [4:0] nbits,
  input wire logic [SSI_MAX_BITS-1:0] word,
  output logic data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev;
  logic [4:0] k;
  logic [15:0] idle;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {prev, k, idle, data} <= '0;
    end
    else
    begin
      prev <= sclk;
      idle <= sclk ? idle + 16'h0001 : 16'h0000;
      // released line: flip it so a stale bit never passes as data
      if (idle == 16'h03E8)
        {k, data} <= {5'h00, ~data};
      if (prev && !sclk)
      begin
        k <= k + 5'h01;
        data <= (k >= 5'h01 && k <= nbits) ? word[nbits - k] : ~data;
      end
    end
  end
endmodule : encif_ssi_enc

// file: test/encif_top_assertions.sv
// encif_chk: port-level checks of the axis encoder interface.
// assumes a single pclk domain; bound to encif_top below.
module encif_chk
  import encif_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire encif_out_t enc_out,
  input wire logic ssi_clk_out,
  input wire logic position_switch_output
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic sc_q, seen, psw_en;
  logic [1:0] mode_q;
  logic [4:0] n_q;
  logic [5:0] pc;
  logic [15:0] hi, lo;
  wire ctl_wr = psel && penable && pready && pwrite && paddr == OFF_CTRL;
  wire fall = sc_q && !ssi_clk_out;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {sc_q, seen, psw_en, mode_q, n_q, pc, hi, lo} <= '0;
    end
    else
    begin
      sc_q <= ssi_clk_out;
      hi <= ssi_clk_out ? hi + 16'h0001 : 16'h0000;
      lo <= ssi_clk_out ? 16'h0000 : lo + 16'h0001;
      if (fall)
        pc <= (hi > SSI_HALF_CYC) ? 6'h01 : pc + 6'h01;
      if (fall)
        seen <= 1'h1;
      // shadow of control so frame length and mode can be judged
      if (ctl_wr)
        {n_q, psw_en, mode_q} <= {pwdata[CTL_BITS_LO +: 5], pwdata[CTL_PSW_EN], pwdata[CTL_MODE_LO +: 2]};
    end
  end
  chk_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready held");
  chk_err_unmapped: assert property (psel && !penable && paddr > OFF_DEMAND |=> pslverr)
    else $error("unmapped access not refused");
  chk_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  chk_ssi_low_half: assert property ($rose(ssi_clk_out) |-> lo == SSI_HALF_CYC)
    else $error("serial clock low width wrong");
  chk_ssi_idle_gap: assert property ($fell(ssi_clk_out) && seen |-> hi == SSI_HALF_CYC || hi >= SSI_GAP_CYC)
    else $error("serial clock high width wrong");
  chk_frame_pulses: assert property (hi == SSI_HALF_CYC + 1 && pc != 6'h00 |-> pc == {1'h0, n_q} + 6'h02)
    else $error("pulses per frame wrong");
  chk_phase_single: assert property (mode_q == ENCIF_MODE_ENC_OUT && $past(mode_q) == ENCIF_MODE_ENC_OUT
    |-> !($changed(enc_out.phase_a) && $changed(enc_out.phase_b)))
    else $error("both phases moved at once");
  chk_switch_enabled: assert property ($rose(position_switch_output) |-> psw_en)
    else $error("switch rose while disabled");
endmodule : encif_chk

bind encif_top encif_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_out(enc_out),
  .ssi_clk_out(ssi_clk_out), .position_switch_output(position_switch_output));

// file: test/encif_top_test.sv
// encif_top_test: scenario bench for the axis encoder interface.
// assumes encif_top, the serial encoder model and the bound checker.
module encif_top_test
  import encif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'h0, presetn = 1'h0, clk_en = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, qa = 1'h0, qb = 1'h0, qz = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [1:0] reg_input = 2'h0;
  logic [31:0] prdata;
  logic pready, pslverr, position_switch_output, irq, ssi_clk_out, sdat;
  logic [24:0] sword = 25'h000_0016;
  encif_inc_t enc_in;
  encif_out_t enc_out, last;
  int miscompares = 0, checked = 0, cyc = 0, ea = 0, eb = 0;
  // marker pulses share the pin with serial data; qz stays low in serial mode
  assign enc_in = '{chan_a: qa, chan_b: qb, chan_z: sdat ^ qz};
  always #4 pclk = ~pclk;
  encif_top uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_in(enc_in),
    .reg_input(reg_input), .enc_out(enc_out), .ssi_clk_out(ssi_clk_out),
    .position_switch_output(position_switch_output), .irq(irq));
  encif_ssi_enc enc (.pclk(pclk), .presetn(presetn), .sclk(ssi_clk_out), .nbits(5'h05), .word(sword), .data(sdat));
  task automatic tally_and_finish;
    $display("TB: %0d checks, %0d mismatches", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  always @(posedge pclk)
  begin
    cyc++;
    if (enc_out.phase_a !== last.phase_a)
      ea++;
    if (enc_out.phase_b !== last.phase_b)
      eb++;
    last = enc_out;
    if (cyc == 100000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    // only the bench timeout ends this wait
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    chk("pready", 32'h0000_0001, 32'(pready));
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'h1, a, d, q, e);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'h0, a, 32'h0000_0000, q, e);
    chk(nm, exp, q);
  endtask : rd
  task automatic quad(input logic fwd, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      {qa, qb} <= fwd ? {~qb, qa} : {qb, ~qa};
      repeat (6) @(posedge pclk);
    end
  endtask : quad
  task automatic steps(input logic up, input int n);
    // a left-high step line would swallow the first step
    qb <= up;
    qa <= 1'h0;
    repeat (n)
    begin
      repeat (10) @(posedge pclk);
      qa <= 1'h1;
      repeat (10) @(posedge pclk);
      qa <= 1'h0;
    end
    repeat (6) @(posedge pclk);
  endtask : steps
  task automatic wait_frame;
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    q = 32'h0000_0000;
    wr(OFF_IRQ_STAT, 32'h0000_0007);
    while (q[IRQ_FRAME] !== 1'h1 && n < 6000)
    begin
      apb(1'h0, OFF_IRQ_STAT, 32'h0000_0000, q, e);
      n++;
    end
    chk("frame flag", 32'h0000_0001, 32'(q[IRQ_FRAME]));
  endtask : wait_frame
  task automatic t_reset;
    logic [31:0] q;
    logic e;
    rd("CTRL", OFF_CTRL, CTRL_RESET);
    apb(1'h0, 8'h2C, 32'h0000_0000, q, e);
    chk("unmapped err", 32'h0000_0001, 32'(e));
    chk("unmapped data", 32'h0000_0000, q);
    $display("test reset done");
  endtask : t_reset
  task automatic t_count;
    wr(OFF_COUNT, 32'h0000_0000);
    quad(1'h1, 6);
    rd("COUNT fwd", OFF_COUNT, 32'h0000_0006);
    quad(1'h0, 9);
    rd("COUNT rev", OFF_COUNT, 32'hFFFF_FFFD);
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_COUNT, 32'h0000_000A);
    steps(1'h1, 2);
    steps(1'h0, 3);
    rd("COUNT step", OFF_COUNT, 32'h0000_0009);
    $display("test count done");
  endtask : t_count
  task automatic t_capture;
    wr(OFF_COUNT, 32'h0000_0064);
    wr(OFF_IRQ_MASK, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0019);
    @(posedge pclk);
    reg_input <= 2'h1;
    repeat (CAPTURE_LIMIT_CYC) @(posedge pclk);
    quad(1'h1, 2);
    rd("CAPTURE", OFF_CAPTURE, 32'h0000_0064);
    rd("IRQ_STAT", OFF_IRQ_STAT, 32'h0000_0001);
    chk("irq set", 32'h0000_0001, 32'(irq));
    wr(OFF_IRQ_MASK, 32'h0000_0007);
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'h0000_0000, 32'(irq));
    wr(OFF_IRQ_MASK, 32'h0000_0000);
    wr(OFF_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    reg_input <= 2'h0;
    wr(OFF_COUNT, 32'h0000_0030);
    wr(OFF_CTRL, 32'h0000_0049);
    qz <= 1'h1;
    quad(1'h1, 1);
    qz <= 1'h0;
    quad(1'h1, 1);
    rd("CAPTURE marker fall", OFF_CAPTURE, 32'h0000_0031);
    $display("test capture done");
  endtask : t_capture
  task automatic t_switch;
    wr(OFF_SW_ON, 32'h0000_000C);
    wr(OFF_SW_OFF, 32'h0000_000E);
    wr(OFF_COUNT, 32'h0000_000A);
    wr(OFF_CTRL, 32'h0000_0081);
    quad(1'h1, 1);
    chk("switch below", 32'h0000_0000, 32'(position_switch_output));
    quad(1'h1, 1);
    chk("switch on", 32'h0000_0001, 32'(position_switch_output));
    rd("STATUS", OFF_STATUS, 32'h0000_0004);
    quad(1'h1, 2);
    chk("switch off", 32'h0000_0000, 32'(position_switch_output));
    $display("test switch done");
  endtask : t_switch
  task automatic t_outputs;
    wr(OFF_DEMAND, 32'h0000_0005);
    {ea, eb} = '0;
    wr(OFF_CTRL, 32'h0000_0003);
    repeat (40) @(posedge pclk);
    chk("edges A", 32'h0000_0003, 32'(ea));
    chk("edges B", 32'h0000_0002, 32'(eb));
    wr(OFF_CTRL, 32'h0000_4005);
    wr(OFF_DEMAND, 32'h0000_0002);
    repeat (40) @(posedge pclk);
    chk("step enable", 32'h0000_0001, 32'(enc_out.enable));
    chk("step dir", 32'h0000_0000, 32'(enc_out.phase_b));
    $display("test outputs done");
  endtask : t_outputs
  task automatic t_serial;
    wr(OFF_DEMAND, 32'h0000_0020);
    wr(OFF_CTRL, 32'h0000_0A07);
    wait_frame();
    rd("measured_position bin", OFF_MEASURED_POSITION, 32'h0000_0016);
    rd("POS_ERR", OFF_POS_ERR, 32'h0000_000A);
    wr(OFF_CTRL, 32'h0000_0B07);
    wait_frame();
    wait_frame();
    rd("measured_position gray", OFF_MEASURED_POSITION, 32'h0000_001B);
    $display("test serial done");
  endtask : t_serial
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_count();
    t_capture();
    t_switch();
    t_outputs();
    t_serial();
    tally_and_finish();
  end
endmodule : encif_top_test
